// ### hdl/scos_cfg.svh
// Constants of the strap, clock and status block.
// Assumes a 100 MHz core clock; all counts derive from it.
`ifndef SCOS_CFG_SVH
`define SCOS_CFG_SVH

// ==========================================================
// Core clock
`define SCOS_CLK_PERIOD_NS   16'h000A
// ==========================================================
// Internal oscillator/PLL half period, seen on the clock out
`define SCOS_PLL_HALF_NS     16'h0050
`define SCOS_PLL_HALF_CYC    (`SCOS_PLL_HALF_NS / `SCOS_CLK_PERIOD_NS)
// ==========================================================
// Panel data shift period
`define SCOS_PANEL_SHIFT_NS  16'h0028
`define SCOS_PANEL_SHIFT_CYC (`SCOS_PANEL_SHIFT_NS / `SCOS_CLK_PERIOD_NS)
// ==========================================================
// Widths and reset values
`define SCOS_DIV_W           8
`define SCOS_BYTE_ZERO       8'h00
`define SCOS_NIB_ZERO        4'h0
`define SCOS_DIV_ZERO        8'h00
`define SCOS_DIV_ONE         8'h01

`endif

// ### hdl/scos_pkg.sv
// Types and helpers of the strap, clock and status block.
// Assumes scos_cfg.svh is visible for the constants it uses.
`include "scos_cfg.svh"

package scos_pkg;

  // ========================================================
  // Panel shifter states
  typedef enum logic [2:0] {
    SCOS_PNL_IDLE = 3'b001,
    SCOS_PNL_HI   = 3'b010,
    SCOS_PNL_LO   = 3'b100
  } scos_pnl_t;

  // ========================================================
  // Pick one nibble of a byte onto the low lines
  function automatic logic [7:0] scos_nib(input logic [7:0] b,
                                         input logic       hi);
    scos_nib = hi ? {`SCOS_NIB_ZERO, b[7:4]}
                  : {`SCOS_NIB_ZERO, b[3:0]};
  endfunction

endpackage

// ### hdl/scos_host_decode.sv
// Host strobe decoder for both bus styles.
// Assumes strobes are synchronous to clk and style is static.
`timescale 1ns/100ps
`include "scos_cfg.svh"

module scos_host_decode (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic enable,
  input  wire logic style_en_rw,
  input  wire logic host_cs,
  input  wire logic host_rd_en,
  input  wire logic host_wr_rw,
  output logic      rd_act,
  output logic      wr_act,
  output logic      rd_end,
  output logic      wr_end
);

  logic rd_now;
  logic wr_now;
  logic rd_reg;
  logic wr_reg;

  // ========================================================
  // Style decode: strobes low-active, or enable plus direction
  always_comb begin
    if (style_en_rw) begin
      rd_now = enable & host_cs & host_rd_en & host_wr_rw;   // [RULE4]
      wr_now = enable & host_cs & host_rd_en & ~host_wr_rw;  // [RULE4]
    end else begin
      rd_now = enable & host_cs & ~host_rd_en;               // [RULE4]
      wr_now = enable & host_cs & ~host_wr_rw;               // [RULE4]
    end
  end

  // Registered activity, ends on the trailing edge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
    end else begin
      rd_reg <= rd_now;
      wr_reg <= wr_now;
    end
  end

  assign rd_act = rd_now;
  assign wr_act = wr_now;
  assign rd_end = rd_reg & ~rd_now;
  assign wr_end = wr_reg & ~wr_now;

endmodule

// ### hdl/scos_top.sv
// Strap capture, clock source, host nibble/byte transfer,
// panel data shifter and command status outputs.
// Assumes all pins synchronous to clk; ext_clock_in is slow.
//
// How it works
// RULE1: Low nrst resets everything; operation resumes after it returns high.
// RULE2: Clock strap low enables oscillator/PLL; high uses ext_clock_in.
// RULE3: Panel strap low gives 4-bit panel bus, high gives 8-bit.
// RULE4: Host style strap low: separate strobes; high: enable plus direction.
// RULE5: Host width strap low: 4-bit nibbles; high: full 8-bit bus.
// RULE6: During read status is 1,0; during write status is 1,1.
// RULE7: With no read or write served, first status bit is 0.
// RULE8: Internal system clock appears on the clock output pin.
// RULE9: In 4-bit host mode host drives only the low nibble.
// RULE10: In 4-bit panel mode only low four panel lines carry data.
// RULE11: Straps are captured once at reset release, then ignored.
`timescale 1ns/100ps
`include "scos_cfg.svh"

module scos_top (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       clock_source_strap,
  input  wire logic       panel_bus_width_strap,
  input  wire logic       host_style_strap,
  input  wire logic       host_bus_width_strap,
  input  wire logic       test_strap,
  input  wire logic       ext_clock_in,
  input  wire logic       host_cs,
  input  wire logic       host_rd_en,
  input  wire logic       host_wr_rw,
  input  wire logic       host_rs,
  input  wire logic [7:0] host_data_in,
  output logic      [7:0] host_data_out,
  output logic            host_data_oe,
  input  wire logic [7:0] user_rd_data,
  output logic            user_rd_ack,
  output logic      [7:0] user_wr_data,
  output logic            user_wr_rs,
  output logic            user_wr_strobe,
  input  wire logic [7:0] panel_in_data,
  input  wire logic       panel_in_valid,
  output logic            panel_in_ready,
  output logic      [7:0] panel_data_bus,
  output logic            panel_shift,
  output logic            op_state_bit_a,
  output logic            op_state_bit_b,
  output logic            osc_enable,
  output logic            pll_enable,
  output logic            clk_out,
  output logic            cfg_valid,
  output logic            test_mode
);
  import scos_pkg::*;

  // ========================================================
  // Strap capture
  logic cfg_valid_reg;
  logic ext_clk_reg;
  logic panel8_reg;
  logic style_reg;
  logic host8_reg;
  logic test_reg;

  // Straps taken at the first edge after release, then frozen
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin                                    // [RULE1]
      cfg_valid_reg <= 1'b0;
      ext_clk_reg   <= 1'b0;
      panel8_reg    <= 1'b0;
      style_reg     <= 1'b0;
      host8_reg     <= 1'b0;
      test_reg      <= 1'b0;
    end else if (!cfg_valid_reg) begin                  // [RULE11]
      cfg_valid_reg <= 1'b1;
      ext_clk_reg   <= clock_source_strap;
      panel8_reg    <= panel_bus_width_strap;
      style_reg     <= host_style_strap;
      host8_reg     <= host_bus_width_strap;
      test_reg      <= ~test_strap;                     // Normally high
    end
  end

  assign cfg_valid = cfg_valid_reg;
  assign test_mode = test_reg;

  // ========================================================
  // Clock source and clock output
  logic                   osc_en_reg;
  logic                   clk_out_reg;
  logic [`SCOS_DIV_W-1:0] pll_cnt_reg;
  logic                   pll_tick;

  // Oscillator and PLL only run in crystal mode
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      osc_en_reg <= 1'b0;
    end else begin
      osc_en_reg <= cfg_valid_reg & ~ext_clk_reg;       // [RULE2]
    end
  end

  // Divider standing in for the PLL output phase
  assign pll_tick = (pll_cnt_reg ==
                     `SCOS_DIV_W'(`SCOS_PLL_HALF_CYC - 1));

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pll_cnt_reg <= `SCOS_DIV_ZERO;
    end else if (!osc_en_reg || pll_tick) begin
      pll_cnt_reg <= `SCOS_DIV_ZERO;
    end else begin
      pll_cnt_reg <= pll_cnt_reg + `SCOS_DIV_ONE;
    end
  end

  // System clock onto the output pin, from either source
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      clk_out_reg <= 1'b0;
    end else if (!cfg_valid_reg) begin
      clk_out_reg <= 1'b0;
    end else if (ext_clk_reg) begin
      clk_out_reg <= ext_clock_in;                      // [RULE2] [RULE8]
    end else if (pll_tick) begin
      clk_out_reg <= ~clk_out_reg;                      // [RULE8]
    end
  end

  assign osc_enable = osc_en_reg;
  assign pll_enable = osc_en_reg;
  assign clk_out    = clk_out_reg;

  // ========================================================
  // Host cycle decode
  logic rd_act;
  logic wr_act;
  logic rd_end;
  logic wr_end;

  scos_host_decode u_decode (
    .clk         (clk),
    .nrst        (nrst),
    .enable      (cfg_valid_reg),
    .style_en_rw (style_reg),
    .host_cs     (host_cs),
    .host_rd_en  (host_rd_en),
    .host_wr_rw  (host_wr_rw),
    .rd_act      (rd_act),
    .wr_act      (wr_act),
    .rd_end      (rd_end),
    .wr_end      (wr_end)
  );

  // ========================================================
  // Host write path
  logic [7:0] wr_hold_reg;
  logic       wr_rs_hold_reg;
  logic [3:0] wr_hi_reg;
  logic       wr_nib_lo_reg;
  logic [7:0] wr_data_reg;
  logic       wr_rs_reg;
  logic       wr_strobe_reg;

  // Data follows the bus while the write strobe is active
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_hold_reg    <= `SCOS_BYTE_ZERO;
      wr_rs_hold_reg <= 1'b0;
    end else if (wr_act) begin
      wr_hold_reg    <= host_data_in;
      wr_rs_hold_reg <= host_rs;
    end
  end

  // Byte per cycle, or high nibble then low nibble
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_hi_reg     <= `SCOS_NIB_ZERO;
      wr_nib_lo_reg <= 1'b0;
      wr_data_reg   <= `SCOS_BYTE_ZERO;
      wr_rs_reg     <= 1'b0;
      wr_strobe_reg <= 1'b0;
    end else begin
      wr_strobe_reg <= 1'b0;
      if (wr_end) begin
        if (host8_reg) begin                            // [RULE5]
          wr_data_reg   <= wr_hold_reg;
          wr_rs_reg     <= wr_rs_hold_reg;
          wr_strobe_reg <= 1'b1;
        end else if (!wr_nib_lo_reg) begin              // [RULE5] [RULE9]
          wr_hi_reg     <= wr_hold_reg[3:0];
          wr_nib_lo_reg <= 1'b1;
        end else begin
          wr_data_reg   <= {wr_hi_reg, wr_hold_reg[3:0]};
          wr_rs_reg     <= wr_rs_hold_reg;
          wr_strobe_reg <= 1'b1;
          wr_nib_lo_reg <= 1'b0;
        end
      end
    end
  end

  assign user_wr_data   = wr_data_reg;
  assign user_wr_rs     = wr_rs_reg;
  assign user_wr_strobe = wr_strobe_reg;

  // ========================================================
  // Host read path
  logic [7:0] rd_out_reg;
  logic       rd_oe_reg;
  logic       rd_nib_lo_reg;
  logic       rd_ack_reg;

  // Bus drive one cycle after the read strobe is seen
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_out_reg <= `SCOS_BYTE_ZERO;
      rd_oe_reg  <= 1'b0;
    end else begin
      rd_oe_reg  <= rd_act;
      rd_out_reg <= host8_reg ? user_rd_data                  // [RULE5]
                  : scos_nib(user_rd_data, ~rd_nib_lo_reg);
    end
  end

  // Nibble pointer and acknowledge once the byte is consumed
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_nib_lo_reg <= 1'b0;
      rd_ack_reg    <= 1'b0;
    end else begin
      rd_ack_reg <= 1'b0;
      if (rd_end) begin
        if (host8_reg || rd_nib_lo_reg) begin
          rd_ack_reg    <= 1'b1;
          rd_nib_lo_reg <= 1'b0;
        end else begin
          rd_nib_lo_reg <= 1'b1;
        end
      end
    end
  end

  assign host_data_out = rd_out_reg;
  assign host_data_oe  = rd_oe_reg;
  assign user_rd_ack   = rd_ack_reg;

  // ========================================================
  // Command status outputs
  logic op_a_reg;
  logic op_b_reg;

  // 1,0 read; 1,1 write; 0,0 otherwise
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      op_a_reg <= 1'b0;                                 // [RULE7]
      op_b_reg <= 1'b0;
    end else begin
      op_a_reg <= rd_act | wr_act;                      // [RULE6] [RULE7]
      op_b_reg <= wr_act;                               // [RULE6]
    end
  end

  assign op_state_bit_a = op_a_reg;
  assign op_state_bit_b = op_b_reg;

  // ========================================================
  // Panel data shifter
  scos_pnl_t              pnl_state_reg;
  scos_pnl_t              pnl_state_next;
  logic [7:0]             pnl_byte_reg;
  logic [7:0]             pnl_bus_reg;
  logic                   pnl_shift_reg;
  logic                   pnl_ready_reg;
  logic [`SCOS_DIV_W-1:0] pnl_cnt_reg;
  logic                   pnl_tick;

  // Shift-rate enable pulse
  assign pnl_tick = (pnl_cnt_reg ==
                     `SCOS_DIV_W'(`SCOS_PANEL_SHIFT_CYC - 1));

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pnl_cnt_reg <= `SCOS_DIV_ZERO;
    end else if (pnl_tick) begin
      pnl_cnt_reg <= `SCOS_DIV_ZERO;
    end else begin
      pnl_cnt_reg <= pnl_cnt_reg + `SCOS_DIV_ONE;
    end
  end

  // Next state: one beat per byte, or two in nibble mode
  always_comb begin
    pnl_state_next = pnl_state_reg;
    unique case (pnl_state_reg)
      SCOS_PNL_IDLE: begin
        if (pnl_ready_reg && panel_in_valid) begin
          pnl_state_next = SCOS_PNL_HI;
        end
      end
      SCOS_PNL_HI: begin
        if (pnl_tick) begin
          pnl_state_next = panel8_reg ? SCOS_PNL_IDLE      // [RULE3]
                                      : SCOS_PNL_LO;
        end
      end
      SCOS_PNL_LO: begin
        if (pnl_tick) begin
          pnl_state_next = SCOS_PNL_IDLE;
        end
      end
      default: pnl_state_next = SCOS_PNL_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pnl_state_reg <= SCOS_PNL_IDLE;
    end else begin
      pnl_state_reg <= pnl_state_next;
    end
  end

  // Byte accept, bus drive and shift pulse
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pnl_byte_reg  <= `SCOS_BYTE_ZERO;
      pnl_bus_reg   <= `SCOS_BYTE_ZERO;
      pnl_shift_reg <= 1'b0;
      pnl_ready_reg <= 1'b0;
    end else begin
      pnl_shift_reg <= 1'b0;
      pnl_ready_reg <= cfg_valid_reg &&
                       (pnl_state_next == SCOS_PNL_IDLE);
      if (pnl_state_reg == SCOS_PNL_IDLE && pnl_ready_reg &&
          panel_in_valid) begin
        pnl_byte_reg <= panel_in_data;
      end
      if (pnl_tick && pnl_state_reg == SCOS_PNL_HI) begin
        pnl_shift_reg <= 1'b1;
        pnl_bus_reg   <= panel8_reg ? pnl_byte_reg          // [RULE3]
                       : scos_nib(pnl_byte_reg, 1'b1);      // [RULE10]
      end
      if (pnl_tick && pnl_state_reg == SCOS_PNL_LO) begin
        pnl_shift_reg <= 1'b1;
        pnl_bus_reg   <= scos_nib(pnl_byte_reg, 1'b0);      // [RULE10]
      end
    end
  end

  assign panel_in_ready = pnl_ready_reg;
  assign panel_data_bus = pnl_bus_reg;
  assign panel_shift    = pnl_shift_reg;

endmodule

// ### verification/scos_top_assertions.sv
// Checker for the strap, clock and status pins of scos_top.
// Assumes it is bound to scos_top and sees its ports only.
`timescale 1ns/100ps

module scos_checker (
  input wire logic clk,
  input wire logic nrst,
  input wire logic host_cs,
  input wire logic host_data_oe,
  input wire logic user_wr_strobe,
  input wire logic panel_in_valid,
  input wire logic panel_in_ready,
  input wire logic panel_shift,
  input wire logic op_state_bit_a,
  input wire logic op_state_bit_b,
  input wire logic osc_enable,
  input wire logic pll_enable,
  input wire logic clk_out,
  input wire logic ext_clock_in,
  input wire logic cfg_valid
);
  // ========================================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_reset_quiet: assert property (
    !$past(nrst) |-> !op_state_bit_a && !user_wr_strobe && !host_data_oe)
    else $error("outputs active right after reset");
  a_osc_pll_match: assert property (
    osc_enable == pll_enable) else $error("osc and pll enables differ");
  a_ext_clk_follow: assert property (
    cfg_valid && $past(cfg_valid) && !osc_enable
    |-> clk_out == $past(ext_clock_in))
    else $error("clock out does not follow external clock");
  a_xtal_half_period: assert property (
    osc_enable && $rose(clk_out)
    |=> $stable(clk_out) [*7] ##1 $fell(clk_out))
    else $error("internal clock half period wrong");
  a_read_status: assert property (
    host_data_oe |-> op_state_bit_a && !op_state_bit_b)
    else $error("status not read while driving bus");
  a_write_pair: assert property (
    op_state_bit_b |-> op_state_bit_a)
    else $error("second status bit without first");
  a_idle_status: assert property (
    !host_cs && !$past(host_cs) && !$past(host_cs, 2) |-> !op_state_bit_a)
    else $error("status busy with no transfer");
  a_strap_frozen: assert property (
    $past(cfg_valid, 2) |-> $stable(osc_enable))
    else $error("clock source changed after capture");
  a_cfg_held: assert property (
    cfg_valid |=> cfg_valid) else $error("config valid dropped");
  a_panel_take: assert property (
    panel_in_valid && panel_in_ready |=> !panel_in_ready)
    else $error("panel ready stayed high after a take");
  a_shift_pulse: assert property (
    panel_shift |=> !panel_shift) else $error("panel shift too long");

  // Main scenarios reached
  c_write: cover property ($rose(op_state_bit_b));
  c_read: cover property ($rose(host_data_oe));
  c_shift: cover property ($rose(panel_shift));
  c_xtal: cover property (osc_enable && $rose(clk_out));
endmodule

bind scos_top scos_checker chk_u (.clk, .nrst, .host_cs, .host_data_oe,
  .user_wr_strobe, .panel_in_valid, .panel_in_ready, .panel_shift,
  .op_state_bit_a, .op_state_bit_b, .osc_enable, .pll_enable, .clk_out,
  .ext_clock_in, .cfg_valid);

// ### verification/scos_host_model.sv
// Host processor model on the parallel host bus.
// Assumes tasks are called just after a rising edge of clk.
`timescale 1ns/100ps

module scos_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] host_data_out,
  input  wire logic       host_data_oe,
  input  wire logic       op_state_bit_a,
  input  wire logic       op_state_bit_b,
  output logic            host_cs,
  output logic            host_rd_en,
  output logic            host_wr_rw,
  output logic            host_rs,
  output logic      [7:0] host_data_in
);
  // ========================================================
  // Bus at rest: strobes inactive, data lines wander
  task automatic rest(input logic sty);
    host_cs = 1'h0;
    host_rd_en = ~sty;
    host_wr_rw = 1'h1;
    host_data_in = ~host_data_in; // Released lines keep no value
  endtask

  initial begin
    host_data_in = 8'h00;
    host_rs = 1'h0;
    rest(1'h0);
  end

  // Three-cycle strobe, answer sampled mid third cycle
  task automatic xfer(input logic sty, wr, rs, input logic [7:0] d,
                      output logic [7:0] q, output logic [2:0] st);
    host_cs = 1'h1;
    host_rs = rs;
    host_data_in = d;
    host_rd_en = sty | wr;
    host_wr_rw = ~wr;
    repeat (2) @(posedge clk);
    #4;
    q = host_data_out;
    st = {host_data_oe, op_state_bit_a, op_state_bit_b};
    @(posedge clk);
    #1;
    rest(sty);
    @(posedge clk); // One idle cycle between strobes
    #1;
  endtask
endmodule

// ### verification/tb_strap_config_and_op_status.sv
// Self-checking bench for scos_top over all strap settings.
// Assumes scos_top, scos_host_model and the checker are compiled.
`timescale 1ns/100ps

module tb_strap_config_and_op_status;
  logic clk = 1'h0, nrst, ext_clock_in, test_strap, host_cs, host_rd_en;
  logic clock_source_strap, panel_bus_width_strap, host_style_strap;
  logic host_bus_width_strap, host_wr_rw, host_rs, host_data_oe;
  logic user_rd_ack, user_wr_rs, user_wr_strobe, panel_in_valid;
  logic panel_in_ready, panel_shift, op_state_bit_a, op_state_bit_b;
  logic osc_enable, pll_enable, clk_out, cfg_valid, test_mode;
  logic [7:0] host_data_in, host_data_out, user_rd_data, user_wr_data;
  logic [7:0] panel_in_data, panel_data_bus;
  logic [7:0] exq[$];
  int error_cnt = 0, samples_checked = 0;

  scos_top dut_u (.clk, .nrst, .clock_source_strap, .panel_bus_width_strap,
    .host_style_strap, .host_bus_width_strap, .test_strap, .ext_clock_in,
    .host_cs, .host_rd_en, .host_wr_rw, .host_rs, .host_data_in,
    .host_data_out, .host_data_oe, .user_rd_data, .user_rd_ack,
    .user_wr_data, .user_wr_rs, .user_wr_strobe, .panel_in_data,
    .panel_in_valid, .panel_in_ready, .panel_data_bus, .panel_shift,
    .op_state_bit_a, .op_state_bit_b, .osc_enable, .pll_enable, .clk_out,
    .cfg_valid, .test_mode);
  scos_host_model host_u (.clk, .host_data_out, .host_data_oe,
    .op_state_bit_a, .op_state_bit_b, .host_cs, .host_rd_en, .host_wr_rw,
    .host_rs, .host_data_in);

  // ========================================================
  // Clocks: core clock and a slow external clock
  always #5 clk = ~clk;
  always begin
    repeat (6) @(posedge clk);
    #1 ext_clock_in = ~ext_clock_in;
  end

  // Compare and count
  task automatic chk(input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic stop_test();
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  // One strap setting: reset, clock, write, read, panel
  task automatic run_cfg(input logic [3:0] c);
    logic [7:0] w, r, p, q;
    logic [2:0] st;
    logic rs, b;
    int n;
    tick();
    nrst = 1'h0;
    {clock_source_strap, panel_bus_width_strap, host_style_strap,
     host_bus_width_strap} = c;
    test_strap = |c;
    repeat (4) tick();
    chk({op_state_bit_a, cfg_valid, host_data_oe, user_wr_strobe}, 0);
    nrst = 1'h1;
    repeat (2) tick();
    {clock_source_strap, panel_bus_width_strap, host_style_strap,
     host_bus_width_strap, test_strap} = 5'($urandom);
    chk({cfg_valid, osc_enable, pll_enable}, {1'h1, ~c[3], ~c[3]});
    chk(test_mode, ~|c);
    repeat (2) begin
      b = clk_out;
      n = 0;
      while (clk_out === b && n < 20) begin tick(); n++; end
    end
    chk(n, c[3] ? 6 : 8);
    w = 8'($urandom);
    rs = 1'($urandom);
    if (c[0]) host_u.xfer(c[1], 1'h1, rs, w, q, st);
    else begin
      host_u.xfer(c[1], 1'h1, rs, {4'($urandom), w[7:4]}, q, st);
      host_u.xfer(c[1], 1'h1, rs, {4'($urandom), w[3:0]}, q, st);
    end
    chk(st, 3'h3);
    n = 0;
    while (user_wr_strobe !== 1'h1 && n < 10) begin tick(); n++; end
    chk({user_wr_strobe, user_wr_rs, user_wr_data}, {1'h1, rs, w});
    r = 8'($urandom);
    user_rd_data = r;
    exq = c[0] ? '{r} : '{{4'h0, r[7:4]}, {4'h0, r[3:0]}};
    while (exq.size() > 0) begin
      host_u.xfer(c[1], 1'h0, 1'h1, 8'($urandom), q, st);
      chk({st, q}, {3'h6, exq.pop_front()});
    end
    n = 0;
    while (user_rd_ack !== 1'h1 && n < 10) begin tick(); n++; end
    chk(user_rd_ack, 1);
    repeat (3) tick();
    chk({op_state_bit_a, host_data_oe}, 0);
    p = 8'($urandom);
    exq = c[2] ? '{p} : '{{4'h0, p[7:4]}, {4'h0, p[3:0]}};
    panel_in_data = p;
    panel_in_valid = 1'h1;
    n = 0;
    while (panel_in_ready !== 1'h1 && n < 10) begin tick(); n++; end
    tick();
    panel_in_valid = 1'h0;
    while (exq.size() > 0 && n < 40) begin
      tick();
      n++;
      if (panel_shift === 1'h1)
        chk(panel_data_bus, exq.pop_front());
    end
    chk(exq.size(), 0);
    $display("config %h finished, mismatches %0d", c, error_cnt);
  endtask

  // Main sequence over every strap setting
  initial begin
    void'($urandom(89));
    {clock_source_strap, panel_bus_width_strap, host_style_strap,
     host_bus_width_strap, test_strap} = 5'h01;
    nrst = 1'h0;
    ext_clock_in = 1'h0;
    user_rd_data = 8'h00;
    panel_in_data = 8'h00;
    panel_in_valid = 1'h0;
    repeat (16) @(posedge clk);
    for (int c = 0; c < 16; c++) run_cfg(4'(c));
    stop_test();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #400000;
    error_cnt++;
    stop_test();
  end
endmodule
